/* logic/mbpc_brake_phase.v */
// Motor holding brake sequencer and start-up phase check, APB slave.
// Assumes one 125 MHz clock, synchronous reset and sampled phase currents
// already in the clock domain; pin inputs pass a three-stage filter.
//
// Overview of operation
// - With check enabled, test all three phases after each initialisation.
// - Phase U passes at 1 % rated current, V and W at 0.5 %.
// - Check lasts at most 10 ms, ends early once all three pass.
// - Skip the check when speed lies outside the standstill window.
// - A phase below threshold raises the phase failure error.
// - Apply the brake whenever speed falls below the brake limit.
// - Speed threshold mode only in open loop; controlled uses timed mode.
// - Separate CW/CCW limits within +-32764, default 0, hysteresis default 1.
// - Speed threshold switching decisions use the setpoint.
// - Timed mode enabled by output assignment; release only with torque.
// - Release delay holds setpoint after brake output, 0..65535 ms, 100.
// - Apply delay postpones control off after close, 0..65535 ms, 100.
// - With contactor control, run contactor delay around the brake.
// - Nonzero setpoint: magnetize, then brake output and release delay.
// - After release delay, follow setpoint and judge by actual speed.
// - Zero setpoint and speed in window: standstill, start apply delay.
// - Apply delay expiry locks the power stage.
// - Any fault drives every digital output low; the code drops brake, stage and contactor only.
// - Motor overload signals an error that switches the motor off.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "mbpc_consts.vh"
`default_nettype none

module mbpc_brake_phase #(
	parameter TICK_CYCLES = `MBPC_TICK_CYCLES
) (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [15:0] setpoint,
	input  wire [15:0] actual_speed,
	input  wire [15:0] current_u,
	input  wire [15:0] current_v,
	input  wire [15:0] current_w,
	input  wire        fault_in,
	input  wire        overload_in,
	output reg         brake_release,
	output reg         stage_enable,
	output reg         contactor_on,
	output reg         phase_fail,
	output reg         overload_error
);

	localparam ST_IDLE    = 3'd0;
	localparam ST_CONTACT = 3'd1;
	localparam ST_MAGNET  = 3'd2;
	localparam ST_RELEASE = 3'd3;
	localparam ST_RUN     = 3'd4;
	localparam ST_APPLY   = 3'd5;
	localparam ST_OFF_DLY = 3'd6;
	localparam ST_PCHK    = 3'd7;

	reg  [31:0] ctrl;
	reg  [15:0] limit_cw;
	reg  [15:0] limit_ccw;
	reg  [15:0] hyst;
	reg  [15:0] release_setpoint_delay;
	reg  [15:0] apply_control_off_delay;
	reg  [15:0] magnetizing_period;
	reg  [15:0] contactor_to_control_delay;
	reg  [15:0] rated_current;
	reg  [15:0] standstill_window;
	reg  [2:0]  fault_sync;
	reg  [2:0]  ovl_sync;
	reg         fault_f;
	reg         ovl_f;
	reg  [16:0] tick_cnt;
	reg         ms_tick;
	reg  [2:0]  state;
	reg  [15:0] ms_cnt;
	reg         timed_active;
	reg  [2:0]  phase_seen;
	reg         standstill;
	reg  [31:0] next_prdata;

	wire phase_check_enable         = ctrl[`MBPC_CTRL_PCHK];
	wire speed_threshold_brake_mode = ctrl[`MBPC_CTRL_OPENLOOP];
	wire motor_contactor_control    = ctrl[`MBPC_CTRL_CONTACT];
	wire wr_en = psel & penable & pwrite;

	// Absolute value of a signed speed word
	function [15:0] mag;
		input [15:0] v;
		begin
			mag = v[15] ? (~v + 16'h0001) : v;
		end
	endfunction

	// Current at least rated times per-mille figure / 1000
	function reached;
		input [15:0] i;
		input [15:0] rated;
		input [3:0]  permille;
		reg   [31:0] lhs;
		reg   [31:0] rhs;
		begin
			lhs = {16'h0000, mag(i)} * 32'd1000;
			rhs = {16'h0000, rated} * {28'h0000000, permille};
			reached = (lhs >= rhs);
		end
	endfunction

	wire in_window = (mag(actual_speed) <= standstill_window);
	wire sp_zero   = (setpoint == 16'h0000);
	wire [2:0] phase_ok = {reached(current_w, rated_current, 4'd5),
		reached(current_v, rated_current, 4'd5),
		reached(current_u, rated_current, 4'd10)};

	// setpoint driven limit, per-direction limit and hysteresis
	wire [15:0] sp_mag   = mag(setpoint);
	wire [15:0] lim_mag  = setpoint[15] ? mag(limit_ccw) : limit_cw;
	wire [16:0] lim_rel  = {1'b0, lim_mag} + {1'b0, mag(hyst)};
	wire        thr_open = ({1'b0, sp_mag} > lim_rel);
	wire        thr_shut = (sp_mag < lim_mag);

	assign pready  = 1'b1;
	assign pslverr = psel & penable & (paddr[11:5] != 7'h00);

	// Three-stage filter; a change counts once stages two and three agree
	always @(posedge sys_clk) begin
		if (reset) begin
			fault_sync <= 3'b000;
			ovl_sync   <= 3'b000;
			fault_f    <= 1'b0;
			ovl_f      <= 1'b0;
		end else begin
			fault_sync <= {fault_sync[1:0], fault_in};
			ovl_sync   <= {ovl_sync[1:0], overload_in};
			if (fault_sync[2] == fault_sync[1])
				fault_f <= fault_sync[2];
			if (ovl_sync[2] == ovl_sync[1])
				ovl_f <= ovl_sync[2];
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			tick_cnt <= 17'h00000;
			ms_tick  <= 1'b0;
		end else if (tick_cnt == TICK_CYCLES - 1) begin
			tick_cnt <= 17'h00000;
			ms_tick  <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
			ms_tick  <= 1'b0;
		end
	end

	// APB write side
	always @(posedge sys_clk) begin
		if (reset) begin
			ctrl                       <= `MBPC_RST_CTRL;
			limit_cw                   <= `MBPC_RST_LIMIT_CW;
			limit_ccw                  <= `MBPC_RST_LIMIT_CCW;
			hyst                       <= `MBPC_RST_HYST;
			release_setpoint_delay     <= `MBPC_RST_RELEASE;
			apply_control_off_delay    <= `MBPC_RST_APPLY;
			magnetizing_period         <= `MBPC_RST_MAGNET;
			contactor_to_control_delay <= `MBPC_RST_CONTACT;
			rated_current              <= `MBPC_RST_RATED;
			standstill_window          <= `MBPC_RST_WINDOW;
		end else begin
			ctrl[`MBPC_CTRL_INIT]   <= 1'b0;
			ctrl[`MBPC_CTRL_CLRERR] <= 1'b0;
			if (wr_en) begin
				case (paddr)
				`MBPC_REG_CTRL: begin
					ctrl[`MBPC_CTRL_PCHK]     <= pwdata[`MBPC_CTRL_PCHK];
					ctrl[`MBPC_CTRL_OPENLOOP] <= pwdata[`MBPC_CTRL_OPENLOOP];
					ctrl[`MBPC_CTRL_CONTACT]  <= pwdata[`MBPC_CTRL_CONTACT];
					ctrl[`MBPC_CTRL_INIT]     <= pwdata[`MBPC_CTRL_INIT];
					ctrl[`MBPC_CTRL_CLRERR]   <= pwdata[`MBPC_CTRL_CLRERR];
					if (!stage_enable)
						ctrl[`MBPC_CTRL_TIMED] <= pwdata[`MBPC_CTRL_TIMED];
				end
				`MBPC_REG_LIMITS: begin
					limit_cw <= (pwdata[15] ? 16'h0000 :
						(pwdata[15:0] > `MBPC_LIMIT_MAX ?
						`MBPC_LIMIT_MAX : pwdata[15:0]));
					limit_ccw <= (!pwdata[31] ? 16'h0000 :
						(pwdata[31:16] < (~`MBPC_LIMIT_MAX + 16'h0001) ?
						(~`MBPC_LIMIT_MAX + 16'h0001) : pwdata[31:16]));
				end
				`MBPC_REG_HYST:
					hyst <= pwdata[15:0];
				`MBPC_REG_DELAYS: begin
					release_setpoint_delay  <= pwdata[15:0];
					apply_control_off_delay <= pwdata[31:16];
				end
				`MBPC_REG_TIMES: begin
					magnetizing_period         <= pwdata[15:0];
					contactor_to_control_delay <= pwdata[31:16];
				end
				`MBPC_REG_RATED:
					rated_current <= pwdata[15:0];
				`MBPC_REG_WINDOW:
					standstill_window <= pwdata[15:0];
				default: ;
				endcase
			end
		end
	end

	wire timed_brake_mode = ctrl[`MBPC_CTRL_TIMED] &
		~speed_threshold_brake_mode;

	// APB read side
	always @* begin
		case (paddr)
		`MBPC_REG_CTRL:   next_prdata = {28'h0000000, ctrl[3:0]};
		`MBPC_REG_LIMITS: next_prdata = {limit_ccw, limit_cw};
		`MBPC_REG_HYST:   next_prdata = {16'h0000, hyst};
		`MBPC_REG_DELAYS: next_prdata = {apply_control_off_delay,
			release_setpoint_delay};
		`MBPC_REG_TIMES:  next_prdata = {contactor_to_control_delay,
			magnetizing_period};
		`MBPC_REG_RATED:  next_prdata = {16'h0000, rated_current};
		`MBPC_REG_STATUS: next_prdata = {16'h0000, 3'b000, phase_seen,
			standstill, overload_error, phase_fail, fault_f,
			contactor_on, stage_enable, brake_release, state};
		`MBPC_REG_WINDOW: next_prdata = {16'h0000, standstill_window};
		default:          next_prdata = 32'h0000_0000;
		endcase
	end

	// Captured in setup so the word stands through the access phase
	always @(posedge sys_clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else begin
			if (psel & ~penable & ~pwrite)
				prdata <= next_prdata;
		end
	end

	// Sequencer, phase check and outputs
	always @(posedge sys_clk) begin
		if (reset) begin
			state          <= ST_IDLE;
			ms_cnt         <= 16'h0000;
			timed_active   <= 1'b0;
			phase_seen     <= 3'b000;
			standstill     <= 1'b0;
			brake_release  <= 1'b0;
			stage_enable   <= 1'b0;
			contactor_on   <= 1'b0;
			phase_fail     <= 1'b0;
			overload_error <= 1'b0;
		end else begin
			if (ovl_f)
				overload_error <= 1'b1;
			else if (ctrl[`MBPC_CTRL_CLRERR])
				overload_error <= 1'b0;
			if (ctrl[`MBPC_CTRL_CLRERR] && state != ST_PCHK)
				phase_fail <= 1'b0;
			if (ms_tick && ms_cnt != 16'hFFFF)
				ms_cnt <= ms_cnt + 16'h0001;
			standstill <= sp_zero & in_window;
			if (fault_f || overload_error) begin
				state         <= ST_IDLE;
				brake_release <= 1'b0;
				stage_enable  <= 1'b0;
				contactor_on  <= 1'b0;
			end else if (ctrl[`MBPC_CTRL_INIT]) begin
				// check after init, only with speed in the standstill window
				if (phase_check_enable && in_window) begin
					state        <= ST_PCHK;
					ms_cnt       <= 16'h0000;
					phase_seen   <= 3'b000;
					stage_enable <= 1'b1;
					// Brake held while the windings are pulsed
					brake_release <= 1'b0;
				end
			end else begin
				case (state)
				ST_PCHK: begin
					phase_seen <= phase_seen | phase_ok;
					// early end or 10 ms limit
					if ((phase_seen | phase_ok) == 3'b111) begin
						state        <= ST_IDLE;
						stage_enable <= 1'b0;
					end else if (ms_cnt >= `MBPC_PCHK_MS) begin
						phase_fail   <= 1'b1;
						state        <= ST_IDLE;
						stage_enable <= 1'b0;
					end
				end
				ST_IDLE: begin
					if (speed_threshold_brake_mode) begin
						stage_enable <= ~sp_zero;
						if (thr_open)
							brake_release <= 1'b1;
						else if (thr_shut)
							brake_release <= 1'b0;
					end else if (!sp_zero) begin
						contactor_on <= 1'b1;
						ms_cnt       <= 16'h0000;
						timed_active <= timed_brake_mode;
						state        <= motor_contactor_control ?
							ST_CONTACT : ST_MAGNET;
					end else begin
						brake_release <= 1'b0;
						stage_enable  <= 1'b0;
						contactor_on  <= 1'b0;
					end
				end
				ST_CONTACT:
					if (ms_cnt >= contactor_to_control_delay) begin
						ms_cnt <= 16'h0000;
						state  <= ST_MAGNET;
					end
				ST_MAGNET: begin
					stage_enable <= 1'b1;
					if (ms_cnt >= magnetizing_period) begin
						// release with torque, only if assigned
						brake_release <= timed_active;
						ms_cnt        <= 16'h0000;
						state         <= ST_RELEASE;
					end
				end
				ST_RELEASE:
					if (ms_cnt >= release_setpoint_delay)
						state <= ST_RUN;
				ST_RUN:
					if (sp_zero && in_window) begin
						brake_release <= 1'b0;
						ms_cnt        <= 16'h0000;
						state         <= ST_APPLY;
					end
				ST_APPLY:
					if (!sp_zero) begin
						brake_release <= timed_active;
						state         <= ST_RUN;
					end else if (ms_cnt >= apply_control_off_delay) begin
						stage_enable <= 1'b0;
						ms_cnt       <= 16'h0000;
						state        <= motor_contactor_control ?
							ST_OFF_DLY : ST_IDLE;
					end
				ST_OFF_DLY:
					if (ms_cnt >= contactor_to_control_delay) begin
						contactor_on <= 1'b0;
						state        <= ST_IDLE;
					end
				default:
					state <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* shared/mbpc_consts.vh */
// Constants of the brake sequencer and phase check block.
// Included by the logic file; holds definitions only.
`ifndef MBPC_CONSTS_VH
`define MBPC_CONSTS_VH

// Register byte offsets
`define MBPC_REG_CTRL      12'h000
`define MBPC_REG_LIMITS    12'h004
`define MBPC_REG_HYST      12'h008
`define MBPC_REG_DELAYS    12'h00C
`define MBPC_REG_TIMES     12'h010
`define MBPC_REG_RATED     12'h014
`define MBPC_REG_STATUS    12'h018
`define MBPC_REG_WINDOW    12'h01C

// Control register field positions
`define MBPC_CTRL_PCHK     0
`define MBPC_CTRL_OPENLOOP 1
`define MBPC_CTRL_TIMED    2
`define MBPC_CTRL_CONTACT  3
`define MBPC_CTRL_INIT     4
`define MBPC_CTRL_CLRERR   5

// Reset values and the limit clamp bound
`define MBPC_RST_CTRL      32'h0000_0000
`define MBPC_RST_LIMIT_CW  16'h0000
`define MBPC_RST_LIMIT_CCW 16'h0000
`define MBPC_RST_HYST      16'h0001
`define MBPC_RST_RELEASE   16'h0064
`define MBPC_RST_APPLY     16'h0064
`define MBPC_RST_MAGNET    16'h0064
`define MBPC_RST_CONTACT   16'h0000
`define MBPC_RST_RATED     16'h03E8
`define MBPC_RST_WINDOW    16'h001E
`define MBPC_LIMIT_MAX     16'h7FFC

// Timing: clock rate and figures in their own units
`define MBPC_CLK_HZ        125000000
`define MBPC_TICK_MS       1
`define MBPC_TICK_CYCLES   (`MBPC_CLK_HZ / 1000 * `MBPC_TICK_MS)
`define MBPC_PCHK_MS       10

`endif

/* sim/mbpc_checker.sv */
// Port checker of the brake sequencer and phase check.
// Sees mbpc_brake_phase ports only; bound below the module.
`timescale 1ns/100ps
`default_nettype none
module mbpc_checker (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        fault_in,
	input wire logic        overload_in,
	input wire logic        brake_release,
	input wire logic        stage_enable,
	input wire logic        contactor_on,
	input wire logic        phase_fail,
	input wire logic        overload_error
);
	wire clr_wr;
	// Errors may only drop after a clear request
	assign clr_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[5];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_fault_all_low: assert property (
		fault_in [*3] |-> ##[0:4] !brake_release && !stage_enable && !contactor_on)
		else $error("outputs stay active under fault");
	a_overload_flag_set: assert property (
		overload_in [*6] |-> overload_error)
		else $error("overload not flagged");
	a_overload_motor_off: assert property (
		overload_error |=> !stage_enable && !brake_release)
		else $error("motor still on with overload");
	a_lock_after_brake: assert property (
		$fell(stage_enable) |-> !brake_release)
		else $error("stage locked with brake released");
	a_fail_brake_held: assert property (
		$rose(phase_fail) |-> !brake_release)
		else $error("phase failure with brake released");
	a_fail_sticky: assert property (
		$fell(phase_fail) |-> $past(clr_wr) || $past(clr_wr, 2))
		else $error("phase failure dropped without clear");
	a_overload_sticky: assert property (
		$fell(overload_error) |-> $past(clr_wr) || $past(clr_wr, 2))
		else $error("overload dropped without clear");
	a_pready_high: assert property (psel && penable |-> pready)
		else $error("wait state inserted");
	a_slverr_map: assert property (
		pslverr == (psel && penable && paddr >= 12'h020))
		else $error("slave error does not match address");
endmodule
bind mbpc_brake_phase mbpc_checker u_chk (.sys_clk, .reset, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .fault_in, .overload_in,
	.brake_release, .stage_enable, .contactor_on, .phase_fail,
	.overload_error);
`default_nettype wire

/* sim/mbpc_motor_model.sv */
// Motor, power stage and holding brake behind the sequencer.
// Currents flow only while the stage drives; the rotor follows the
// setpoint only when released with the stage driving, else it shows the coasting speed given.
`timescale 1ns/100ps
`default_nettype none
module mbpc_motor_model (
	input  wire logic        sys_clk,
	input  wire logic        brake_release,
	input  wire logic        stage_enable,
	input  wire logic [15:0] setpoint,
	input  wire logic [15:0] coast_speed,
	input  wire logic [47:0] phase_level,
	output logic      [15:0] actual_speed,
	output logic      [15:0] current_u,
	output logic      [15:0] current_v,
	output logic      [15:0] current_w
);
	always_ff @(posedge sys_clk) begin
		// Unpowered windings carry no current
		{current_w, current_v, current_u} <= stage_enable ? phase_level : 48'h0;
		actual_speed <= brake_release && stage_enable ? setpoint : coast_speed;
	end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench of the brake sequencer and phase check.
// Drives APB and drive inputs; the motor model closes the loop.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        fault_in, overload_in, brake_release, stage_enable;
	logic        contactor_on, phase_fail, overload_error;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] setpoint, actual_speed, coast_speed;
	logic [15:0] current_u, current_v, current_w;
	logic [47:0] phase_level;
	logic [33:0] notes[$];
	logic [33:0] note;
	int          num_errors, comparisons, n, r;
	logic [15:0] sp_tab[8] = '{16'h0034, 16'h0033, 16'h0032, 16'h0031,
		16'h0033, 16'h0034, 16'hFFCC, 16'hFFCF};
	logic [7:0]  br_tab = 8'h67;
	logic [47:0] lvl_tab[4] = '{48'h0005_0005_000A, 48'h0005_0005_0009,
		48'h0005_0004_000A, 48'h0004_0005_000A};

	mbpc_brake_phase #(.TICK_CYCLES(10)) u_dut (.sys_clk, .reset, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.setpoint, .actual_speed, .current_u, .current_v, .current_w,
		.fault_in, .overload_in, .brake_release, .stage_enable,
		.contactor_on, .phase_fail, .overload_error);
	mbpc_motor_model u_motor (.sys_clk, .brake_release, .stage_enable,
		.setpoint, .coast_speed, .phase_level, .actual_speed, .current_u,
		.current_v, .current_w);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_rng(input string s, input int lo, input int hi,
		input int g);
		comparisons++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		notes.push_back({1'b0, a >= 12'h020, d});
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		notes.push_back({1'b1, a >= 12'h020, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return brake_release;
			1: return stage_enable;
			default: return overload_error;
		endcase
	endfunction
	task automatic wait_for(input int k, input logic v, input int lim);
		n = 0;
		while (sig(k) !== v && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Completed transfers are matched against the oldest note
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			note = notes.pop_front();
			chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
			if (note[33] && !note[32])
				chk("prdata", note[31:0], prdata);
		end
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		{psel, penable, pwrite, fault_in, overload_in} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		setpoint = 16'h0000;
		coast_speed = 16'h0000;
		phase_level = lvl_tab[0];
		num_errors = 0;
		comparisons = 0;
		reset = 1'b1;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		r = $urandom(32'hB08A2D35);
		rd(12'h000, 32'h0000_0000);
		rd(12'h004, 32'h0000_0000);
		rd(12'h008, 32'h0000_0001);
		rd(12'h00C, 32'h0064_0064);
		rd(12'h010, 32'h0000_0064);
		rd(12'h01C, 32'h0000_001E);
		rd(12'h014, 32'h0000_03E8);
		rd(12'h018, 32'h0000_0200);
		rd(12'h020, 32'h0000_0000);
		r = $urandom_range(32764, 0);
		wr(12'h004, {16'h0000 - r[15:0], r[15:0]});
		rd(12'h004, {16'h0000 - r[15:0], r[15:0]});
		wr(12'h004, 32'h8000_7FFF);
		rd(12'h004, 32'h8004_7FFC);
		wr(12'h004, 32'hFFCE_0032);
		wr(12'h000, 32'h0000_0002);
		for (int i = 0; i < 8; i++) begin
			setpoint <= sp_tab[i];
			repeat (30) @(posedge sys_clk);
			chk("brake_release", {31'h0, br_tab[i]}, {31'h0, brake_release});
		end
		setpoint <= 16'h0000;
		repeat (30) @(posedge sys_clk);
		wr(12'h00C, 32'h0002_0003);
		wr(12'h010, 32'h0002_0002);
		wr(12'h000, 32'h0000_000C);
		r = $urandom_range(1000, 100);
		setpoint <= r[15:0];
		wait_for(0, 1'b1, 200);
		chk_rng("release time", 20, 70, n);
		chk("contactor_on", 32'h1, {31'h0, contactor_on});
		chk("stage_enable", 32'h1, {31'h0, stage_enable});
		wr(12'h000, 32'h0000_0008);
		rd(12'h000, 32'h0000_000C);
		setpoint <= 16'h0000;
		wait_for(0, 1'b0, 100);
		chk_rng("apply time", 0, 60, n);
		wait_for(1, 1'b0, 100);
		chk_rng("lock time", 10, 35, n);
		setpoint <= 16'h0100;
		wait_for(0, 1'b1, 200);
		chk_rng("restart time", 20, 90, n);
		fault_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("outputs", 32'h0, {29'h0, brake_release, stage_enable, contactor_on});
		setpoint <= 16'h0000;
		fault_in <= 1'b0;
		wait_for(1, 1'b0, 200);
		wr(12'h000, 32'h0000_0020);
		overload_in <= 1'b1;
		wait_for(2, 1'b1, 20);
		chk_rng("overload time", 2, 6, n);
		overload_in <= 1'b0;
		repeat (6) @(posedge sys_clk);
		wr(12'h000, 32'h0000_0020);
		repeat (3) @(posedge sys_clk);
		chk("overload_error", 32'h0, {31'h0, overload_error});
		setpoint <= 16'h0080;
		wait_for(1, 1'b1, 100);
		chk_rng("plain start", 2, 5, n);
		repeat (60) @(posedge sys_clk);
		chk("plain brake", 32'h0, {31'h0, brake_release});
		setpoint <= 16'h0000;
		wait_for(1, 1'b0, 100);
		chk_rng("plain stop", 10, 60, n);
		for (int i = 0; i < 4; i++) begin
			phase_level <= lvl_tab[i];
			wr(12'h000, 32'h0000_0011);
			wait_for(1, 1'b1, 40);
			chk_rng("check start", 0, 39, n);
			wait_for(1, 1'b0, 200);
			chk_rng("check time", i ? 85 : 0, i ? 125 : 80, n);
			chk("phase_fail", i != 0, {31'h0, phase_fail});
			wr(12'h000, 32'h0000_0020);
		end
		wr(12'h000, 32'h0000_0010);
		wait_for(1, 1'b1, 150);
		chk("disabled check", 150, n);
		coast_speed <= 16'h0064;
		wr(12'h000, 32'h0000_0011);
		wait_for(1, 1'b1, 150);
		chk("moving check", 150, n);
		chk("phase_fail", 32'h0, {31'h0, phase_fail});
		tally_and_finish();
	end
endmodule
`default_nettype wire
